// ==== common/fsr_pkg.sv ====
// constants and types for the status register read block
package fsr_pkg;
    localparam logic [7:0] FSR_OPC_STATUS_READ = 8'hD7;
    // density code value is arbitrary
    localparam logic [3:0] FSR_DENSITY_CODE    = 4'hA;
    // field positions, both bytes
    localparam int FSR_BIT_READY = 7;
    // first byte
    localparam int FSR_BIT_CMP   = 6;
    localparam int FSR_DEN_MSB   = 5;
    localparam int FSR_DEN_LSB   = 2;
    localparam int FSR_BIT_PROT  = 1;
    localparam int FSR_BIT_PAGE  = 0;
    // second byte
    localparam int FSR_BIT_RES6  = 6;
    localparam int FSR_BIT_FAULT = 5;
    localparam int FSR_BIT_RES4  = 4;
    localparam int FSR_BIT_LOCK  = 3;
    localparam int FSR_BIT_PS2   = 2;
    localparam int FSR_BIT_PS1   = 1;
    localparam int FSR_BIT_ES    = 0;
    // reset values
    localparam logic       FSR_CMP_RST   = 1'h0;
    localparam logic       FSR_FAULT_RST = 1'h0;
    localparam logic       FSR_SO_RST    = 1'h0;
    localparam logic [2:0] FSR_IDX_TOP   = 3'h7;
    localparam logic [2:0] FSR_IDX_BOT   = 3'h0;

    typedef enum logic [1:0] {
        FSR_IDLE,
        FSR_OPCODE,
        FSR_STREAM,
        FSR_IGNORE
    } fsr_state_t;
endpackage

// ==== common/fsr_pin_if.sv ====
// synchronised serial pin events between syncer and core
`timescale 1ns/1ps
interface fsr_pin_if;
    logic sel;
    logic sck_rise;
    logic sck_fall;
    logic si_bit;

    modport syncer (output sel, output sck_rise, output sck_fall,
                    output si_bit);
    modport core   (input sel, input sck_rise, input sck_fall,
                    input si_bit);
endinterface

// ==== logic/fsr_pin_sync.sv ====
// two-flop synchronisers and clock edge finder for the serial pins
`timescale 1ns/1ps
module fsr_pin_sync
    import fsr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic spi_cs_n,
    input  wire logic spi_sck,
    input  wire logic spi_si,
    fsr_pin_if.syncer pins
);
    logic [2:0] meta_q;
    logic [2:0] sync_q;
    logic       sck_prev_q;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            meta_q     <= 3'h1;
            sync_q     <= 3'h1;
            sck_prev_q <= 1'h0;
        end else begin
            meta_q     <= {spi_si, spi_sck, spi_cs_n};
            sync_q     <= meta_q;
            sck_prev_q <= sync_q[1];
        end
    end

    // edges seen on the second stage only
    assign pins.sel      = ~sync_q[0];
    assign pins.sck_rise = sync_q[1] & ~sck_prev_q;
    assign pins.sck_fall = ~sync_q[1] & sck_prev_q;
    assign pins.si_bit   = sync_q[2];
endmodule // fsr_pin_sync

// ==== logic/fsr_flag_hold.sv ====
// held compare result and erase/program fault flag
`timescale 1ns/1ps
module fsr_flag_hold
    import fsr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic compare_done,
    input  wire logic compare_mismatch,
    input  wire logic ep_done,
    input  wire logic ep_fault,
    input  wire logic ep_aborted,
    output logic      compare_q,
    output logic      fault_q
);
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            compare_q <= FSR_CMP_RST;
        end else if (compare_done) begin
            compare_q <= compare_mismatch;
        end
    end

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            fault_q <= FSR_FAULT_RST;
        end else if (ep_done) begin
            fault_q <= ep_fault & ~ep_aborted;
        end
    end

    ////////////////////////////////////////////////////////////////
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_cmp_hold;
        !compare_done |=> $stable(compare_q);
    endproperty
    a_cmp_hold: assert property (p_cmp_hold)
        else $error("compare flag moved without compare end");

    property p_cmp_update;
        compare_done |=> compare_q == $past(compare_mismatch);
    endproperty
    a_cmp_update: assert property (p_cmp_update)
        else $error("compare flag not written at compare end");

    property p_fault_update;
        ep_done && !ep_aborted |=> fault_q == $past(ep_fault);
    endproperty
    a_fault_update: assert property (p_fault_update)
        else $error("fault flag not refreshed at op end");

    property p_fault_abort;
        ep_done && ep_aborted |=> !fault_q;
    endproperty
    a_fault_abort: assert property (p_fault_abort)
        else $error("fault flag set by aborted op");
endmodule // fsr_flag_hold

// ==== logic/fsr_status_read.sv ====
// serial status register read: opcode decode and two-byte stream
`timescale 1ns/1ps
module fsr_status_read
    import fsr_pkg::*;
(
    input  wire logic ref_clk,
    input  wire logic nrst,
    input  wire logic spi_cs_n,
    input  wire logic spi_sck,
    input  wire logic spi_si,
    output logic      spi_so,
    output logic      spi_so_oe,
    input  wire logic op_busy,
    input  wire logic compare_done,
    input  wire logic compare_mismatch,
    input  wire logic protect_enabled,
    input  wire logic page_binary,
    input  wire logic ep_done,
    input  wire logic ep_fault,
    input  wire logic ep_aborted,
    input  wire logic lockdown_allowed,
    input  wire logic prog_suspended_buf_one,
    input  wire logic prog_suspended_buf_two,
    input  wire logic erase_suspended,
    output logic      buf_one_write_block,
    output logic      buf_two_write_block
);
    ////////////////////////////////////////////////////////////////
    // pin synchronisers and held flags

    fsr_pin_if pins ();

    fsr_pin_sync u_sync (
        .ref_clk  (ref_clk),
        .nrst     (nrst),
        .spi_cs_n (spi_cs_n),
        .spi_sck  (spi_sck),
        .spi_si   (spi_si),
        .pins     (pins)
    );

    logic compare_q;
    logic fault_q;

    fsr_flag_hold u_flags (
        .ref_clk          (ref_clk),
        .nrst             (nrst),
        .compare_done     (compare_done),
        .compare_mismatch (compare_mismatch),
        .ep_done          (ep_done),
        .ep_fault         (ep_fault),
        .ep_aborted       (ep_aborted),
        .compare_q        (compare_q),
        .fault_q          (fault_q)
    );

    ////////////////////////////////////////////////////////////////
    // live status bytes

    function automatic logic [7:0] status_byte(input logic second);
        logic [7:0] b;
        b = 8'h00;
        b[FSR_BIT_READY] = ~op_busy;
        if (!second) begin
            b[FSR_BIT_CMP] = compare_q;
            b[FSR_DEN_MSB:FSR_DEN_LSB] = FSR_DENSITY_CODE;
            b[FSR_BIT_PROT] = protect_enabled;
            b[FSR_BIT_PAGE] = page_binary;
        end else begin
            // reserved positions stay at zero
            b[FSR_BIT_FAULT] = fault_q;
            b[FSR_BIT_LOCK]  = lockdown_allowed;
            b[FSR_BIT_PS2]   = prog_suspended_buf_two;
            b[FSR_BIT_PS1]   = prog_suspended_buf_one;
            b[FSR_BIT_ES]    = erase_suspended;
        end
        return b;
    endfunction

    // suspended buffers refuse modifying commands
    assign buf_two_write_block = prog_suspended_buf_two;
    assign buf_one_write_block = prog_suspended_buf_one;

    ////////////////////////////////////////////////////////////////
    // command state

    fsr_state_t state_q;
    logic [7:0] opc_q;
    logic [2:0] opc_cnt_q;
    logic [7:0] opc_full;
    logic       opc_last;

    assign opc_full = {opc_q[6:0], pins.si_bit};
    assign opc_last = (state_q == FSR_OPCODE) && pins.sck_rise
                      && (opc_cnt_q == FSR_IDX_TOP);

    // no busy gating: the read is served at any moment
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_q <= FSR_IDLE;
        end else if (!pins.sel) begin
            state_q <= FSR_IDLE;
        end else begin
            unique case (state_q)
                FSR_IDLE: begin
                    state_q <= FSR_OPCODE;
                end
                FSR_OPCODE: begin
                    if (opc_last) begin
                        if (opc_full == FSR_OPC_STATUS_READ) begin
                            state_q <= FSR_STREAM;
                        end else begin
                            state_q <= FSR_IGNORE;
                        end
                    end
                end
                FSR_STREAM: begin
                    state_q <= FSR_STREAM;
                end
                FSR_IGNORE: begin
                    state_q <= FSR_IGNORE;
                end
            endcase
        end
    end

    // opcode sampled on rising serial clock, msb first
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            opc_q     <= 8'h00;
            opc_cnt_q <= FSR_IDX_BOT;
        end else if (state_q != FSR_OPCODE) begin
            opc_cnt_q <= FSR_IDX_BOT;
        end else if (pins.sck_rise) begin
            opc_q     <= opc_full;
            opc_cnt_q <= opc_cnt_q + 3'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // output stream

    logic [2:0] bit_idx_q;
    logic       byte_sel_q;
    logic [7:0] hold_q;
    logic [7:0] live_byte;
    logic       stream_fall;

    // process form so that live flag changes inside the function wake it
    always_comb begin
        live_byte = status_byte(byte_sel_q);
    end
    assign stream_fall = (state_q == FSR_STREAM) && pins.sel
                         && pins.sck_fall;

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bit_idx_q  <= FSR_IDX_TOP;
            byte_sel_q <= 1'h0;
            hold_q     <= 8'h00;
        end else if (state_q != FSR_STREAM) begin
            bit_idx_q  <= FSR_IDX_TOP;
            byte_sel_q <= 1'h0;
        end else if (stream_fall) begin
            bit_idx_q <= bit_idx_q - 3'h1;
            if (bit_idx_q == FSR_IDX_TOP) begin
                hold_q <= live_byte;
            end
            if (bit_idx_q == FSR_IDX_BOT) begin
                byte_sel_q <= ~byte_sel_q;
            end
        end
    end

    // data changes only after a falling edge, msb first
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            spi_so <= FSR_SO_RST;
        end else if (stream_fall) begin
            if (bit_idx_q == FSR_IDX_TOP) begin
                spi_so <= live_byte[FSR_BIT_READY];
            end else begin
                spi_so <= hold_q[bit_idx_q];
            end
        end
    end

    // host polls until ready rises; the stream keeps serving it
    assign spi_so_oe = (state_q == FSR_STREAM);

    ////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);

    property p_opcode_starts;
        opc_last && pins.sel && opc_full == FSR_OPC_STATUS_READ
            |=> state_q == FSR_STREAM ##1 spi_so_oe;
    endproperty
    a_opcode_starts: assert property (p_opcode_starts)
        else $error("status opcode did not start the stream");

    property p_other_opcode;
        opc_last && pins.sel && opc_full != FSR_OPC_STATUS_READ
            |=> !spi_so_oe;
    endproperty
    a_other_opcode: assert property (p_other_opcode)
        else $error("output driven for a foreign opcode");

    property p_bit_step;
        stream_fall && bit_idx_q != FSR_IDX_BOT
            |=> bit_idx_q == $past(bit_idx_q) - 3'h1;
    endproperty
    a_bit_step: assert property (p_bit_step)
        else $error("bit index did not step on falling clock");

    property p_wrap;
        stream_fall && bit_idx_q == FSR_IDX_BOT
            |=> byte_sel_q != $past(byte_sel_q)
                && bit_idx_q == FSR_IDX_TOP;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("byte select did not alternate");

    property p_ready_first;
        stream_fall && bit_idx_q == FSR_IDX_TOP
            |=> spi_so == !$past(op_busy);
    endproperty
    a_ready_first: assert property (p_ready_first)
        else $error("ready flag not live in top bit");

    property p_busy_accept;
        state_q == FSR_IDLE && pins.sel && op_busy
            |=> state_q == FSR_OPCODE;
    endproperty
    a_busy_accept: assert property (p_busy_accept)
        else $error("command refused while busy");

    property p_release;
        spi_so_oe && !pins.sel |=> !spi_so_oe [*2];
    endproperty
    a_release: assert property (p_release)
        else $error("output not released after deselect");

    property p_hold_between_falls;
        !stream_fall |=> $stable(spi_so);
    endproperty
    a_hold_between_falls: assert property (p_hold_between_falls)
        else $error("output moved without falling clock");

    property p_reserved_zero;
        stream_fall && byte_sel_q && bit_idx_q == FSR_IDX_TOP
            |=> !hold_q[FSR_BIT_RES6] && !hold_q[FSR_BIT_RES4];
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved status bit read as one");

    property p_density;
        stream_fall && !byte_sel_q && bit_idx_q == FSR_IDX_TOP
            |=> hold_q[FSR_DEN_MSB:FSR_DEN_LSB] == FSR_DENSITY_CODE;
    endproperty
    a_density: assert property (p_density)
        else $error("density code wrong in first byte");

    property p_second_fields;
        stream_fall && byte_sel_q && bit_idx_q == FSR_IDX_TOP
            |=> hold_q[FSR_BIT_ES] == $past(erase_suspended)
                && hold_q[FSR_BIT_LOCK] == $past(lockdown_allowed);
    endproperty
    a_second_fields: assert property (p_second_fields)
        else $error("second byte fields not captured live");

    property p_first_fields;
        stream_fall && !byte_sel_q && bit_idx_q == FSR_IDX_TOP
            |=> hold_q[FSR_BIT_CMP] == $past(compare_q)
                && hold_q[FSR_BIT_PROT] == $past(protect_enabled)
                && hold_q[FSR_BIT_PAGE] == $past(page_binary);
    endproperty
    a_first_fields: assert property (p_first_fields)
        else $error("first byte flags not captured live");

    property p_second_flags;
        stream_fall && byte_sel_q && bit_idx_q == FSR_IDX_TOP
            |=> hold_q[FSR_BIT_FAULT] == $past(fault_q)
                && hold_q[FSR_BIT_PS2] == $past(prog_suspended_buf_two)
                && hold_q[FSR_BIT_PS1] == $past(prog_suspended_buf_one);
    endproperty
    a_second_flags: assert property (p_second_flags)
        else $error("second byte suspend or fault flag wrong");

    property p_shift_bits;
        stream_fall && bit_idx_q != FSR_IDX_TOP
            |=> spi_so == $past(hold_q[bit_idx_q]);
    endproperty
    a_shift_bits: assert property (p_shift_bits)
        else $error("held bit not shifted out in order");

    property p_sel_drop;
        !pins.sel |=> state_q == FSR_IDLE;
    endproperty
    a_sel_drop: assert property (p_sel_drop)
        else $error("deselect did not end the command");

    property p_fresh_opcode;
        $rose(state_q == FSR_OPCODE) |-> opc_cnt_q == FSR_IDX_BOT;
    endproperty
    a_fresh_opcode: assert property (p_fresh_opcode)
        else $error("new select did not start a fresh opcode");

    cover property (stream_fall && byte_sel_q
                    && bit_idx_q == FSR_IDX_BOT);
    cover property (spi_so_oe && !pins.sel
                    && bit_idx_q != FSR_IDX_TOP);
    cover property (spi_so_oe && $fell(op_busy) ##[1:400]
                    spi_so_oe && $rose(!op_busy));
    c_foreign: cover property (state_q == FSR_IGNORE
                               && pins.sck_fall);
    c_busy_stream: cover property (stream_fall && op_busy
                                   && bit_idx_q == FSR_IDX_TOP);
endmodule // fsr_status_read

// ==== test/fsr_spi_host.sv ====
// spi host model: select, clock and data for the status read
`timescale 1ns/1ps
module fsr_spi_host (
    output logic      spi_cs_n,
    output logic      spi_sck,
    output logic      spi_si,
    input  wire logic spi_so,
    input  wire logic spi_so_oe
);
    localparam time HALF = 40ns;
    // no pull on the line: released output reads as inverse of last bit
    wire so_line = spi_so_oe ? spi_so : ~spi_so;

    initial begin
        spi_cs_n = 1'h1;
        spi_sck  = 1'h0;
        spi_si   = 1'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // select, then opcode msb first; ends with sck high after bit 0
    task automatic start(input logic [7:0] op);
        #1;
        spi_cs_n = 1'h0;
        for (int i = 7; i >= 0; i--) begin
            #HALF spi_sck = 1'h0;
            spi_si = op[i];
            #HALF spi_sck = 1'h1;
        end
    endtask

    // clock out n bits, sample on each rising sck
    task automatic get_bits(input int n, output logic [7:0] v,
                            output logic [3:0] n_oe);
        #1;
        v = 8'h00;
        n_oe = 4'h0;
        for (int i = 0; i < n; i++) begin
            #HALF spi_sck = 1'h0;
            spi_si = ~spi_si;
            #HALF spi_sck = 1'h1;
            v = {v[6:0], so_line};
            n_oe = n_oe + {3'h0, spi_so_oe};
        end
    endtask

    // sck parks low, then deselect
    task automatic stop();
        #HALF spi_sck = 1'h0;
        #HALF spi_cs_n = 1'h1;
        #HALF;
    endtask
endmodule // fsr_spi_host

// ==== test/testbench.sv ====
// self-checking bench for the serial status register read
`timescale 1ns/1ps
module testbench
    import fsr_pkg::*;
;
    logic ref_clk, nrst, spi_cs_n, spi_sck, spi_si, spi_so, spi_so_oe;
    logic op_busy, compare_done, compare_mismatch, protect_enabled;
    logic page_binary, ep_done, ep_fault, ep_aborted, lockdown_allowed;
    logic prog_suspended_buf_one, prog_suspended_buf_two;
    logic erase_suspended, buf_one_write_block, buf_two_write_block;
    logic cmp_m, flt_m;
    logic [7:0] v;
    logic [3:0] k;
    int err_total, n_checks, nb;

    fsr_status_read i_fsr_status_read (
        .ref_clk, .nrst, .spi_cs_n, .spi_sck, .spi_si, .spi_so,
        .spi_so_oe, .op_busy, .compare_done, .compare_mismatch,
        .protect_enabled, .page_binary, .ep_done, .ep_fault,
        .ep_aborted, .lockdown_allowed, .prog_suspended_buf_one,
        .prog_suspended_buf_two, .erase_suspended,
        .buf_one_write_block, .buf_two_write_block
    );
    fsr_spi_host i_fsr_spi_host (
        .spi_cs_n, .spi_sck, .spi_si, .spi_so, .spi_so_oe
    );

    initial ref_clk = 1'h0;
    always #2 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////
    function automatic logic [7:0] exp_b1();
        return {~op_busy, cmp_m, FSR_DENSITY_CODE, protect_enabled,
                page_binary};
    endfunction
    function automatic logic [7:0] exp_b2();
        return {~op_busy, 1'h0, flt_m, 1'h0, lockdown_allowed,
                prog_suspended_buf_two, prog_suspended_buf_one,
                erase_suspended};
    endfunction

    task automatic chk(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            err_total++;
        end
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // one-cycle engine pulses; mismatch and fault wander while idle
    task automatic engine(input logic cd, input logic cm, input logic ed,
                          input logic ef, input logic ea);
        @(posedge ref_clk);
        compare_done <= cd;
        compare_mismatch <= cm;
        ep_done <= ed;
        ep_fault <= ef;
        ep_aborted <= ea;
        if (cd) cmp_m = cm;
        if (ed) flt_m = ef & ~ea;
        @(posedge ref_clk);
        compare_done <= 1'h0;
        ep_done <= 1'h0;
        {compare_mismatch, ep_fault, ep_aborted} <= 3'($urandom);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        #200us;
        err_total++;
        finish_test();
    end

    initial begin
        err_total = 0;
        n_checks = 0;
        cmp_m = FSR_CMP_RST;
        flt_m = FSR_FAULT_RST;
        nrst = 1'h0;
        {op_busy, compare_done, compare_mismatch, protect_enabled} = 4'h0;
        {page_binary, ep_done, ep_fault, ep_aborted} = 4'h0;
        {lockdown_allowed, prog_suspended_buf_one} = 2'h0;
        {prog_suspended_buf_two, erase_suspended} = 2'h0;
        void'($urandom(50));
        repeat (10) @(posedge ref_clk);
        nrst <= 1'h1;
        repeat (4) @(posedge ref_clk);
        chk("oe_idle", 8'h00, {7'h00, spi_so_oe});
        // foreign opcode: output never enabled
        i_fsr_spi_host.start(8'h3F);
        i_fsr_spi_host.get_bits(8, v, k);
        i_fsr_spi_host.stop();
        chk("oe_refused", 8'h00, {4'h0, k});
        for (int t = 0; t < 15; t++) begin
            engine(1'($urandom), 1'($urandom), (t < 2) | 1'($urandom),
                   (t < 2) | 1'($urandom), (t == 1) | 1'($urandom));
            @(posedge ref_clk);
            {op_busy, protect_enabled, page_binary, lockdown_allowed,
             prog_suspended_buf_one, prog_suspended_buf_two,
             erase_suspended} <= 7'($urandom);
            i_fsr_spi_host.start(FSR_OPC_STATUS_READ);
            nb = 2 + $urandom_range(3);
            for (int b = 0; b < nb; b++) begin
                if (b > 0) begin
                    @(posedge ref_clk);
                    op_busy <= 1'($urandom);
                end
                i_fsr_spi_host.get_bits(8, v, k);
                chk("oe_stream", 8'h08, {4'h0, k});
                if (b % 2 == 0) begin
                    chk("byte1", exp_b1(), v);
                end else begin
                    chk("byte2", exp_b2(), v);
                end
            end
            chk("wr_block", {6'h00, prog_suspended_buf_two,
                prog_suspended_buf_one}, {6'h00, buf_two_write_block,
                buf_one_write_block});
            // every third pass a partial byte, then deselect; next read starts fresh
            if (t % 3 == 2) i_fsr_spi_host.get_bits(3, v, k);
            i_fsr_spi_host.stop();
            repeat (8) @(posedge ref_clk);
            chk("oe_release", 8'h00, {7'h00, spi_so_oe});
        end
        finish_test();
    end
endmodule // testbench
